// file: atevg_pkg.sv
/*
  atevg_pkg: register offsets, field positions, widths and reset values
  of the axis threshold event generator.
  assumes: nothing beyond a SystemVerilog compiler.
*/
package atevg_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int SAMPLE_W = 16;
  localparam int LIMIT_W = 15;
  localparam int DUR_W = 7;
  localparam int NUM_EVT = 6;
  // register offsets
  localparam logic [6:0] OFS_SOURCE = 7'h31;
  localparam logic [6:0] OFS_X_HIGH = 7'h32;
  localparam logic [6:0] OFS_X_LOW = 7'h33;
  localparam logic [6:0] OFS_Y_HIGH = 7'h34;
  localparam logic [6:0] OFS_Y_LOW = 7'h35;
  localparam logic [6:0] OFS_Z_HIGH = 7'h36;
  localparam logic [6:0] OFS_Z_LOW = 7'h37;
  localparam logic [6:0] OFS_DURATION = 7'h38;
  // field positions
  localparam int SRC_ZERO_BIT = 7;
  localparam int SRC_PENDING_BIT = 6;
  localparam int DUR_HOLD_BIT = 7;
  localparam int THR_HIGH_USED = 7;
  // reset values
  localparam logic [7:0] RST_THRESHOLD = 8'h00;
  localparam logic [7:0] RST_DURATION = 8'h00;
  localparam logic [5:0] RST_FLAGS = 6'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;
endpackage : atevg_pkg

// file: atevg_persist_filter.sv
/*
  atevg_persist_filter: duration filter and hold release for one event.
  assumes: sample_strobe is a one-cycle pulse per output sample.
*/
`timescale 1ns/100ps
`default_nettype none
module atevg_persist_filter (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // sample stream
  input wire logic sample_strobe,
  input wire logic cond,
  // configuration
  input wire logic hold_en,
  input wire logic [atevg_pkg::DUR_W-1:0] min_persist_count,
  // result
  output logic active
);
  logic [atevg_pkg::DUR_W-1:0] on_cnt;
  logic [atevg_pkg::DUR_W-1:0] rel_cnt;
  wire logic persisted = (on_cnt >= min_persist_count);
  wire logic released = (rel_cnt >= min_persist_count);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      on_cnt <= '0;
      rel_cnt <= '0;
      active <= 1'b0;
    end else if (sample_strobe) begin
      if (cond) begin
        rel_cnt <= '0;
        if (!active && persisted) begin
          active <= 1'b1;
        end else if (!active) begin
          on_cnt <= on_cnt + 7'h01;
        end
      end else begin
        on_cnt <= '0;
        if (active && !hold_en) begin
          active <= 1'b0;
        end else if (active && released) begin
          active <= 1'b0;
          rel_cnt <= '0;
        end else if (active) begin
          rel_cnt <= rel_cnt + 7'h01;
        end
      end
    end
  end
endmodule // atevg_persist_filter
`default_nettype wire

// file: atevg_event_gen.sv
/*
  atevg_event_gen: threshold event generator for three rate axes with
  source register, limits, duration filter and one event line.
  assumes: register port driven by the serial interface decoder on
  clk_sys; samples are synchronous and marked by sample_valid.
*/
`timescale 1ns/100ps
`default_nettype none
module atevg_event_gen (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // register port
  input wire logic [atevg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [atevg_pkg::DATA_W-1:0] reg_wdata,
  output logic [atevg_pkg::DATA_W-1:0] reg_rdata,
  // configuration bits
  input wire logic combine_and,
  input wire logic latch_request_enable,
  input wire logic [atevg_pkg::NUM_EVT-1:0] event_enable,
  // sample stream
  input wire logic sample_valid,
  input wire logic [atevg_pkg::SAMPLE_W-1:0] sample_x,
  input wire logic [atevg_pkg::SAMPLE_W-1:0] sample_y,
  input wire logic [atevg_pkg::SAMPLE_W-1:0] sample_z,
  // event output
  output logic event_line_one
);
  // limit assembled from its two bytes
  function automatic logic signed [atevg_pkg::SAMPLE_W-1:0] limit_of(
    input logic [7:0] hi, input logic [7:0] lo);
    limit_of = {1'b0, hi[6:0], lo};
  endfunction

  logic [7:0] x_threshold_high;
  logic [7:0] x_threshold_low;
  logic [7:0] y_threshold_high;
  logic [7:0] y_threshold_low;
  logic [7:0] z_threshold_high;
  logic [7:0] z_threshold_low;
  logic [7:0] event_duration;
  logic [atevg_pkg::NUM_EVT-1:0] source_flags;
  logic combined_q;

  wire logic signed [atevg_pkg::SAMPLE_W-1:0] x_limit_value =
    limit_of(x_threshold_high, x_threshold_low);
  wire logic signed [atevg_pkg::SAMPLE_W-1:0] y_limit_value =
    limit_of(y_threshold_high, y_threshold_low);
  wire logic signed [atevg_pkg::SAMPLE_W-1:0] z_limit_value =
    limit_of(z_threshold_high, z_threshold_low);
  wire logic signed [atevg_pkg::SAMPLE_W-1:0] sx = sample_x;
  wire logic signed [atevg_pkg::SAMPLE_W-1:0] sy = sample_y;
  wire logic signed [atevg_pkg::SAMPLE_W-1:0] sz = sample_z;

  // per-axis compares against the zero-extended limit
  wire logic x_over = (sx > x_limit_value);
  wire logic x_under = (sx < x_limit_value);
  wire logic y_over = (sy > y_limit_value);
  wire logic y_under = (sy < y_limit_value);
  wire logic z_over = (sz > z_limit_value);
  wire logic z_under = (sz < z_limit_value);

  // raw conditions, order z above, z below, y above, y below, x above, x below
  wire logic [atevg_pkg::NUM_EVT-1:0] raw_cond = {
    z_over, z_under,
    y_over, y_under,
    x_over, x_under};

  wire logic hold_en = event_duration[atevg_pkg::DUR_HOLD_BIT];
  wire logic [atevg_pkg::DUR_W-1:0] min_persist_count =
    event_duration[atevg_pkg::DUR_W-1:0];
  wire logic [atevg_pkg::NUM_EVT-1:0] filtered;

  genvar gi;
  generate
    for (gi = 0; gi < atevg_pkg::NUM_EVT; gi++) begin : g_evt
      atevg_persist_filter u_filter (
        .clk_sys(clk_sys),
        .reset(reset),
        .sample_strobe(sample_valid),
        .cond(raw_cond[gi]),
        .hold_en(hold_en),
        .min_persist_count(min_persist_count),
        .active(filtered[gi])
      );
    end
  endgenerate

  // enabled events and their combination
  wire logic [atevg_pkg::NUM_EVT-1:0] live_events = filtered & event_enable;
  wire logic any_enabled = |event_enable;
  wire logic and_combined = any_enabled && (&(filtered | ~event_enable));
  wire logic or_combined = |live_events;
  wire logic combined = combine_and ? and_combined : or_combined;
  wire logic comb_rise = combined && !combined_q;

  // register access decode
  wire logic rd_source = reg_rd && (reg_addr == atevg_pkg::OFS_SOURCE);
  wire logic wr_x_hi = reg_wr && (reg_addr == atevg_pkg::OFS_X_HIGH);
  wire logic wr_x_lo = reg_wr && (reg_addr == atevg_pkg::OFS_X_LOW);
  wire logic wr_y_hi = reg_wr && (reg_addr == atevg_pkg::OFS_Y_HIGH);
  wire logic wr_y_lo = reg_wr && (reg_addr == atevg_pkg::OFS_Y_LOW);
  wire logic wr_z_hi = reg_wr && (reg_addr == atevg_pkg::OFS_Z_HIGH);
  wire logic wr_z_lo = reg_wr && (reg_addr == atevg_pkg::OFS_Z_LOW);
  wire logic wr_dur = reg_wr && (reg_addr == atevg_pkg::OFS_DURATION);
  wire logic [7:0] wdata_high = {1'b0, reg_wdata[atevg_pkg::THR_HIGH_USED-1:0]};

  // pending bit: set by a rising combination, set wins over clear
  wire logic pending_clear = rd_source || (!latch_request_enable && !combined);
  wire logic next_pending = comb_rise || (event_line_one && !pending_clear);

  // flags: keep set bits and add live events while a latched request is pending, else follow live
  wire logic flags_frozen = latch_request_enable && event_line_one && !rd_source;
  wire logic [atevg_pkg::NUM_EVT-1:0] next_flags =
    flags_frozen ? (source_flags | live_events) : live_events;

  // source byte assembled from its field positions
  logic [7:0] source_value;
  always_comb begin
    source_value = '0;
    source_value[atevg_pkg::SRC_ZERO_BIT] = 1'b0;
    source_value[atevg_pkg::SRC_PENDING_BIT] = event_line_one;
    source_value[atevg_pkg::NUM_EVT-1:0] = source_flags;
  end
  logic [7:0] next_rdata;
  always_comb begin
    unique case (reg_addr)
      atevg_pkg::OFS_SOURCE: next_rdata = source_value;
      atevg_pkg::OFS_X_HIGH: next_rdata = x_threshold_high;
      atevg_pkg::OFS_X_LOW: next_rdata = x_threshold_low;
      atevg_pkg::OFS_Y_HIGH: next_rdata = y_threshold_high;
      atevg_pkg::OFS_Y_LOW: next_rdata = y_threshold_low;
      atevg_pkg::OFS_Z_HIGH: next_rdata = z_threshold_high;
      atevg_pkg::OFS_Z_LOW: next_rdata = z_threshold_low;
      atevg_pkg::OFS_DURATION: next_rdata = event_duration;
      default: next_rdata = atevg_pkg::UNMAPPED_RDATA;
    endcase
  end

  // threshold and duration registers; source offset takes no write
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      x_threshold_high <= atevg_pkg::RST_THRESHOLD;
      x_threshold_low <= atevg_pkg::RST_THRESHOLD;
      y_threshold_high <= atevg_pkg::RST_THRESHOLD;
      y_threshold_low <= atevg_pkg::RST_THRESHOLD;
      z_threshold_high <= atevg_pkg::RST_THRESHOLD;
      z_threshold_low <= atevg_pkg::RST_THRESHOLD;
      event_duration <= atevg_pkg::RST_DURATION;
    end else begin
      if (wr_x_hi) begin
        x_threshold_high <= wdata_high;
      end
      if (wr_x_lo) begin
        x_threshold_low <= reg_wdata;
      end
      if (wr_y_hi) begin
        y_threshold_high <= wdata_high;
      end
      if (wr_y_lo) begin
        y_threshold_low <= reg_wdata;
      end
      if (wr_z_hi) begin
        z_threshold_high <= wdata_high;
      end
      if (wr_z_lo) begin
        z_threshold_low <= reg_wdata;
      end
      if (wr_dur) begin
        event_duration <= reg_wdata;
      end
    end
  end

  // source state and read data
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      source_flags <= atevg_pkg::RST_FLAGS;
      event_line_one <= 1'b0;
      combined_q <= 1'b0;
      reg_rdata <= atevg_pkg::RST_RDATA;
    end else begin
      source_flags <= next_flags;
      event_line_one <= next_pending;
      combined_q <= combined;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end
endmodule // atevg_event_gen
`default_nettype wire

// file: atevg_host_model.sv
/*
  atevg_host_model: host side of the register port, wr and rd tasks.
  assumes: strobes move on falling edges of clk_sys, one access at a time.
*/
`timescale 1ns/100ps
`default_nettype none
module atevg_host_model (
  // clock
  input wire logic clk_sys,
  // register port
  output logic [6:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 7'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  // rd waits two edges so the registered answer has landed
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
endmodule // atevg_host_model
`default_nettype wire

// file: atevg_event_gen_assertions.sv
/*
  atevg_event_gen_assertions: port checks of the event generator.
  assumes: bound to atevg_event_gen; one register access per cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module atevg_event_gen_assertions (
  // watched ports
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [atevg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [atevg_pkg::DATA_W-1:0] reg_rdata,
  input wire logic latch_request_enable,
  input wire logic [atevg_pkg::NUM_EVT-1:0] event_enable,
  input wire logic sample_valid,
  input wire logic event_line_one
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire src_rd = reg_rd && reg_addr == atevg_pkg::OFS_SOURCE;
  wire lim_hi = reg_addr == atevg_pkg::OFS_X_HIGH || reg_addr == atevg_pkg::OFS_Y_HIGH
    || reg_addr == atevg_pkg::OFS_Z_HIGH;
  wire unmapped = reg_addr < atevg_pkg::OFS_SOURCE || reg_addr > atevg_pkg::OFS_DURATION;
  wire latched_high = latch_request_enable && event_line_one;
  wire no_enables = (event_enable == 6'h00);
  src_top_zero_a: assert property (src_rd |-> ##1 !reg_rdata[7])
    else $error("source bit 7 not zero");
  pending_copy_a: assert property (src_rd |-> ##1 reg_rdata[6] == $past(event_line_one))
    else $error("pending bit differs from event line");
  unmapped_zero_a: assert property (reg_rd && unmapped |-> ##1 reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  limit_top_zero_a: assert property (reg_rd && lim_hi |-> ##1 !reg_rdata[7])
    else $error("limit high byte bit 7 set");
  read_clear_a: assert property (src_rd && !$past(sample_valid) |=> !event_line_one)
    else $error("source read left event line high");
  latch_keep_a: assert property (latched_high && !src_rd |=> event_line_one)
    else $error("latched event dropped without read");
  rise_after_sample_a: assert property ($rose(event_line_one) |-> $past(sample_valid, 2))
    else $error("event line rose without a sample");
  no_enable_a: assert property (no_enables && !event_line_one |=> !event_line_one)
    else $error("event with no enables");
endmodule // atevg_event_gen_assertions
bind atevg_event_gen atevg_event_gen_assertions u_chk (.clk_sys, .reset, .reg_addr, .reg_rd,
  .reg_rdata, .latch_request_enable, .event_enable, .sample_valid, .event_line_one);
`default_nettype wire

// file: atevg_event_gen_test.sv
/*
  atevg_event_gen_test: register and event scenarios of the generator.
  assumes: atevg_pkg, host model and checker compiled before.
*/
`timescale 1ns/100ps
`default_nettype none
module atevg_event_gen_test;
  logic clk_sys, reset, combine_and, latch_request_enable, sample_valid, reg_wr, reg_rd;
  logic [5:0] event_enable;
  logic [15:0] sample_x, sample_y, sample_z;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rv;
  logic event_line_one;
  int err_total, tests_run, cycles;
  atevg_event_gen dut (.clk_sys, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .combine_and, .latch_request_enable, .event_enable, .sample_valid,
    .sample_x, .sample_y, .sample_z, .event_line_one);
  atevg_host_model host (.clk_sys, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks=%0d errors=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    host.rd(a, rv);
    chk(rv, exp);
  endtask
  // one sample: axis a (3 = all) gets v, others sit on the limit
  task automatic hit(input int a, input logic [15:0] v);
    @(negedge clk_sys);
    sample_valid = 1'b1;
    sample_x = (a == 0 || a == 3) ? v : 16'h0100;
    sample_y = (a == 1 || a == 3) ? v : 16'h0100;
    sample_z = (a == 2 || a == 3) ? v : 16'h0100;
    @(negedge clk_sys);
    sample_valid = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    {reset, combine_and, latch_request_enable, sample_valid} = 4'hF;
    {combine_and, latch_request_enable, sample_valid} = 3'h0;
    event_enable = 6'h00;
    {sample_x, sample_y, sample_z} = 48'h0;
    repeat (4) @(negedge clk_sys);
    reset = 1'b0;
    for (int a = 'h31; a <= 'h38; a++) rd_chk(7'(a), 8'h00);
    host.wr(atevg_pkg::OFS_SOURCE, 8'hFF);
    rd_chk(atevg_pkg::OFS_SOURCE, 8'h00);
    rd_chk(7'h3F, 8'h00);
    host.wr(atevg_pkg::OFS_X_HIGH, 8'hFF);
    rd_chk(atevg_pkg::OFS_X_HIGH, 8'h7F);
    host.wr(atevg_pkg::OFS_X_LOW, 8'hA5);
    rd_chk(atevg_pkg::OFS_X_LOW, 8'hA5);
    for (int a = 'h32; a <= 'h37; a++) host.wr(7'(a), a[0] ? 8'h00 : 8'h01);
    latch_request_enable = 1'b1;
    for (int i = 0; i < 6; i++) begin
      event_enable = 6'(1 << i);
      hit(i / 2, i[0] ? 16'h0200 : 16'hFF00);
      chk(event_line_one, 1'b1);
      hit(i / 2, 16'h0100);
      chk(event_line_one, 1'b1);
      rd_chk(atevg_pkg::OFS_SOURCE, 8'h40 | 8'(1 << i));
      rd_chk(atevg_pkg::OFS_SOURCE, 8'h00);
      hit(i / 2, i[0] ? 16'hFF00 : 16'h0200);
      chk(event_line_one, 1'b0);
      hit(i / 2, 16'h0100);
    end
    latch_request_enable = 1'b0;
    combine_and = 1'b1;
    event_enable = 6'h0A;
    hit(0, 16'h0200);
    chk(event_line_one, 1'b0);
    hit(3, 16'h0200);
    chk(event_line_one, 1'b1);
    hit(3, 16'h0100);
    chk(event_line_one, 1'b0);
    combine_and = 1'b0;
    event_enable = 6'h02;
    host.wr(atevg_pkg::OFS_DURATION, 8'h82);
    rd_chk(atevg_pkg::OFS_DURATION, 8'h82);
    for (int k = 0; k < 3; k++) begin
      hit(0, 16'h0200);
      chk(event_line_one, k == 2);
    end
    for (int k = 0; k < 3; k++) begin
      hit(0, 16'h0100);
      chk(event_line_one, k != 2);
    end
    // unlatched read clears the line while the condition still stands
    host.wr(atevg_pkg::OFS_DURATION, 8'h00);
    event_enable = 6'h30;
    hit(2, 16'h0200);
    chk(event_line_one, 1'b1);
    rd_chk(atevg_pkg::OFS_SOURCE, 8'h60);
    chk(event_line_one, 1'b0);
    hit(2, 16'h0100);
    rd_chk(atevg_pkg::OFS_SOURCE, 8'h00);
    stop_test();
  end
endmodule // atevg_event_gen_test
`default_nettype wire
